// ===== rtl/lpm_defines.svh
// Purpose: register offsets, field positions and reset values of the power controller
// Assumes: classic Wishbone, 32-bit data, byte addresses
// Notes:   definitions only
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LPM_OFS_CTRL      8'h00
`define LPM_OFS_MBOX      8'h04
`define LPM_OFS_STATUS    8'h08
`define LPM_OFS_WAKE      8'h0C
`define LPM_OFS_PULL      8'h10
`define LPM_OFS_DRIVE     8'h14
`define LPM_OFS_GPIO_SEL  8'h18
`define LPM_OFS_GPIO_OUT  8'h1C
`define LPM_OFS_GPIO_OE   8'h20
`define LPM_OFS_GPIO_IN   8'h24

// ----------------------------------------------------------------
// control and mailbox fields
// ----------------------------------------------------------------
`define LPM_CTRL_SUSP_BIT 0
`define LPM_CTRL_STBY_BIT 1
`define LPM_CTRL_CTSP_BIT 2
`define LPM_MBOX_SUSP     8'hA5
`define LPM_MBOX_STBY     8'h5A

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LPM_RST_PULL      32'h5555_5555
`define LPM_RST_DRIVE     8'h00
`define LPM_RST_ZERO      32'h0000_0000

`endif

// ===== rtl/lpm_pkg.sv
// Purpose: types shared by the power controller files
// Assumes: nothing beyond the defines header
// Notes:   wake and power groups travel as packed structs
package lpm_pkg;

    typedef enum logic [1:0] {
        LPM_NORMAL  = 2'b00,
        LPM_SUSPEND = 2'b01,
        LPM_STANDBY = 2'b11
    } lpm_mode_type;

    typedef enum logic [1:0] {
        LPM_PULL_NONE = 2'b00,
        LPM_PULL_UP   = 2'b01,
        LPM_PULL_DOWN = 2'b10
    } lpm_pull_type;

    typedef enum logic [1:0] {
        LPM_DRV_FULL    = 2'b00,
        LPM_DRV_3QUART  = 2'b01,
        LPM_DRV_HALF    = 2'b10,
        LPM_DRV_QUART   = 2'b11
    } lpm_drive_type;

    typedef struct packed {
        logic dp_edge;
        logic dm_edge;
        logic id_edge;
        logic vbus;
        logic cts;
        logic ctl0;
        logic reset_pin;
    } lpm_wake_type;

    typedef struct packed {
        logic phy_en;
        logic usb_if_hold;
        logic clk_en;
        logic pll_en;
        logic xtal_en;
        logic xcvr_en;
        logic core_pwr_en;
        logic mem_retain;
        logic buf_retain;
        logic pc_reset;
    } lpm_pwr_type;

endpackage

// ===== rtl/lpm_sync.sv
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: bits are independent levels
// Notes:   only the second stage leaves the module
`timescale 1ns/1ps
module lpm_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    // rst_val_i is a constant at every instance
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= rst_val_i;
            q_o      <= rst_val_i;
        end else if (ce_i) begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule

// ===== rtl/lpm_ctrl.sv
// Purpose: low-power mode sequencer with pad hold, pull, drive and spare-pin GPIO control
// Assumes: pins are asynchronous and pass the synchroniser; ext_* strobes are on clk_i
// Notes:   Behaviour
// Behaviour
// - suspend disables fast PHY, bus held suspended
// - suspend gates all clocks and PLLs
// - suspend freezes pads and USB interface state
// - suspend retains registers, buffers and RAM
// - non-reset suspend wake keeps program counter
// - suspend entered by firmware or mailbox write
// - suspend wakes on D+/D-/ID/VBUS/CTL0/reset
// - clear-to-send level wakes, polarity programmable
// - standby keeps config and RAM, not buffers
// - standby wake resets program counter, restarts core
// - GPIO configuration kept during standby
// - standby stops crystal, PLL, transceiver, core power
// - standby entered by firmware or host register write
// - standby wakes only on VBUS/CTS/CTL0/reset
// - core power loss clears all, firmware reload
// - pads tristate, pull-up or pull-down, hold
// - drive strength four levels per interface
// - spare control pins but fifteen become GPIO
// - fixed JTAG pull-ups and clock pull-down
`timescale 1ns/1ps
`include "lpm_defines.svh"
module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int NUM_CTL   = 16,
    parameter int NUM_SER   = 8,
    parameter int NUM_IFACE = 4
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         ce_i,
    // wishbone slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [7:0]                   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    // external processor mailbox strobe
    input  wire logic                         ext_mbox_wr_i,
    input  wire logic [7:0]                   ext_mbox_dat_i,
    // wake pins and core power-good
    input  wire logic                         usb_dp_i,
    input  wire logic                         usb_dm_i,
    input  wire logic                         dual_role_id_pin_i,
    input  wire logic                         vbus_det_i,
    input  wire logic                         uart_cts_i,
    input  wire logic                         reset_pin_n_i,
    input  wire logic                         core_pwr_good_i,
    // core function side of the spare pins
    input  wire logic [NUM_CTL+NUM_SER-1:0]   func_out_i,
    input  wire logic [NUM_CTL+NUM_SER-1:0]   func_oe_i,
    // pads
    input  wire logic [NUM_CTL+NUM_SER-1:0]   pad_i,
    output logic      [NUM_CTL+NUM_SER-1:0]   pad_o,
    output logic      [NUM_CTL+NUM_SER-1:0]   pad_oe_o,
    output logic      [NUM_CTL+NUM_SER-1:0]   pad_pu_o,
    output logic      [NUM_CTL+NUM_SER-1:0]   pad_pd_o,
    output logic      [2*NUM_IFACE-1:0]       drive_o,
    output logic      [2:0]                   jtag_pu_o,
    output logic                              jtag_tck_pd_o,
    // power control
    output lpm_pwr_type                       pwr_o,
    output lpm_mode_type                      mode_o,
    output logic                              fw_reload_o
);
    localparam int NP = NUM_CTL + NUM_SER;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int NS = NP + 7;
    logic [NS-1:0] sync_q;
    logic [NS-1:0] sync_rv;
    logic [NP-1:0] pad_sync;
    logic          dp_s, dm_s, id_s, vbus_s, cts_s, rst_n_s, pwr_ok_s;

    assign sync_rv = {{NP{1'b0}}, 7'h03};

    lpm_sync #(.WIDTH(NS)) u_sync (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .rst_val_i (sync_rv),
        .d_i       ({pad_i, usb_dp_i, usb_dm_i, dual_role_id_pin_i, vbus_det_i,
                     uart_cts_i, reset_pin_n_i, core_pwr_good_i}),
        .q_o       (sync_q)
    );

    assign {pad_sync, dp_s, dm_s, id_s, vbus_s, cts_s, rst_n_s, pwr_ok_s} = sync_q;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    lpm_mode_type         mode_reg;
    lpm_mode_type         mode_next;
    logic                 cts_pol_reg;
    logic [2*NP-1:0]      pull_reg;
    logic [2*NUM_IFACE-1:0] drive_reg;
    logic [NP-1:0]        gpio_sel_reg;
    logic [NP-1:0]        gpio_out_reg;
    logic [NP-1:0]        gpio_oe_reg;
    logic [6:0]           wake_reg;
    logic                 reload_reg;
    logic                 pc_reset_reg;
    logic                 pwr_lost;
    logic [2:0]           prev_reg;
    logic                 wb_req;
    logic                 wb_wr;
    logic [31:0]          wmask;
    logic                 fw_susp, fw_stby, mb_susp, mb_stby;
    lpm_wake_type         wake;
    logic                 wake_susp, wake_stby;

    // core power loss clears everything like a cold start
    assign pwr_lost = !pwr_ok_s;
    assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr    = wb_req && wb_we_i;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{wb_sel_i[b]}};
        end
    end

    // ----------------------------------------------------------------
    // wake detection
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg <= 3'h0;
        end else if (ce_i) begin
            prev_reg <= {dp_s, dm_s, id_s};
        end
    end

    assign wake.dp_edge   = dp_s != prev_reg[2];
    assign wake.dm_edge   = dm_s != prev_reg[1];
    assign wake.id_edge   = id_s != prev_reg[0];
    assign wake.vbus      = vbus_s;
    assign wake.cts       = cts_s == cts_pol_reg;
    assign wake.ctl0      = pad_sync[0];
    assign wake.reset_pin = !rst_n_s;

    assign wake_susp = |wake;
    // data-line and id changes are ignored in standby
    assign wake_stby = wake.vbus || wake.cts || wake.ctl0 || wake.reset_pin;

    // ----------------------------------------------------------------
    // entry requests
    // ----------------------------------------------------------------
    assign fw_susp = wb_wr && wb_adr_i == `LPM_OFS_CTRL && wb_sel_i[0]
                     && wb_dat_i[`LPM_CTRL_SUSP_BIT];
    assign fw_stby = wb_wr && wb_adr_i == `LPM_OFS_CTRL && wb_sel_i[0]
                     && wb_dat_i[`LPM_CTRL_STBY_BIT];
    assign mb_susp = (ext_mbox_wr_i && ext_mbox_dat_i == `LPM_MBOX_SUSP)
                     || (wb_wr && wb_adr_i == `LPM_OFS_MBOX && wb_sel_i[0]
                         && wb_dat_i[7:0] == `LPM_MBOX_SUSP);
    assign mb_stby = (ext_mbox_wr_i && ext_mbox_dat_i == `LPM_MBOX_STBY)
                     || (wb_wr && wb_adr_i == `LPM_OFS_MBOX && wb_sel_i[0]
                         && wb_dat_i[7:0] == `LPM_MBOX_STBY);

    // ----------------------------------------------------------------
    // mode sequencer
    // ----------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            LPM_NORMAL: begin
                // suspend wins when both arrive together
                if (fw_susp || mb_susp) begin
                    mode_next = LPM_SUSPEND;
                end else if (fw_stby || mb_stby) begin
                    mode_next = LPM_STANDBY;
                end
            end
            LPM_SUSPEND: begin
                if (wake_susp) begin
                    mode_next = LPM_NORMAL;
                end
            end
            LPM_STANDBY: begin
                if (wake_stby) begin
                    mode_next = LPM_NORMAL;
                end
            end
            default: begin
                mode_next = LPM_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || pwr_lost) begin
            mode_reg <= LPM_NORMAL;
        end else if (ce_i) begin
            mode_reg <= mode_next;
        end
    end

    // program counter restart: after standby, or any wake by the reset pin
    always_ff @(posedge clk_i) begin
        if (rst_i || pwr_lost) begin
            pc_reset_reg <= 1'b0;
        end else if (ce_i) begin
            pc_reset_reg <= (mode_reg == LPM_STANDBY && wake_stby)
                            || (mode_reg == LPM_SUSPEND && wake.reset_pin);
        end
    end

    // set on power loss, cleared only by a write of one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_reg <= 1'b1;
        end else if (ce_i) begin
            if (pwr_lost) begin
                reload_reg <= 1'b1;
            end else if (wb_wr && wb_adr_i == `LPM_OFS_STATUS && wb_sel_i[0] && wb_dat_i[2]) begin
                reload_reg <= 1'b0;
            end
        end
    end

    // wake cause is sticky; a new cause beats a clearing write
    always_ff @(posedge clk_i) begin
        if (rst_i || pwr_lost) begin
            wake_reg <= 7'h00;
        end else if (ce_i) begin
            if (wb_wr && wb_adr_i == `LPM_OFS_WAKE && wb_sel_i[0]) begin
                wake_reg <= wake_reg & ~wb_dat_i[6:0];
            end
            if (mode_reg == LPM_SUSPEND && wake_susp) begin
                wake_reg <= (wb_wr && wb_adr_i == `LPM_OFS_WAKE && wb_sel_i[0] ?
                             wake_reg & ~wb_dat_i[6:0] : wake_reg) | wake;
            end else if (mode_reg == LPM_STANDBY && wake_stby) begin
                wake_reg <= (wb_wr && wb_adr_i == `LPM_OFS_WAKE && wb_sel_i[0] ?
                             wake_reg & ~wb_dat_i[6:0] : wake_reg)
                            | (wake & 7'b0001111);
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // contents survive both low-power modes; only reset or power loss clears them
    always_ff @(posedge clk_i) begin
        if (rst_i || pwr_lost) begin
            cts_pol_reg  <= 1'b0;
            pull_reg     <= (2*NP)'({2{`LPM_RST_PULL}});
            drive_reg    <= (2*NUM_IFACE)'(`LPM_RST_DRIVE);
            gpio_sel_reg <= NP'(`LPM_RST_ZERO);
            gpio_out_reg <= NP'(`LPM_RST_ZERO);
            gpio_oe_reg  <= NP'(`LPM_RST_ZERO);
        end else if (ce_i && wb_wr) begin
            case (wb_adr_i)
                `LPM_OFS_CTRL: begin
                    if (wb_sel_i[0]) begin
                        cts_pol_reg <= wb_dat_i[`LPM_CTRL_CTSP_BIT];
                    end
                end
                `LPM_OFS_PULL: begin
                    // only the low sixteen pads are reachable over the bus
                    pull_reg[31:0] <= (pull_reg[31:0] & ~wmask) | (wb_dat_i & wmask);
                end
                `LPM_OFS_DRIVE: begin
                    if (wb_sel_i[0]) begin
                        drive_reg <= wb_dat_i[2*NUM_IFACE-1:0];
                    end
                end
                `LPM_OFS_GPIO_SEL: begin
                    gpio_sel_reg <= (gpio_sel_reg & ~wmask[NP-1:0]) | (wb_dat_i[NP-1:0] & wmask[NP-1:0]);
                end
                `LPM_OFS_GPIO_OUT: begin
                    gpio_out_reg <= (gpio_out_reg & ~wmask[NP-1:0]) | (wb_dat_i[NP-1:0] & wmask[NP-1:0]);
                end
                `LPM_OFS_GPIO_OE: begin
                    gpio_oe_reg <= (gpio_oe_reg & ~wmask[NP-1:0]) | (wb_dat_i[NP-1:0] & wmask[NP-1:0]);
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pads
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_pad
            // control line fifteen stays with the interface
            logic use_gpio;
            assign use_gpio = gpio_sel_reg[gi] && (gi != NUM_CTL - 1);

            // pad levels frozen while any low-power mode is active
            always_ff @(posedge clk_i) begin
                if (rst_i || pwr_lost) begin
                    pad_o[gi]    <= 1'b0;
                    pad_oe_o[gi] <= 1'b0;
                end else if (ce_i && mode_reg == LPM_NORMAL) begin
                    pad_o[gi]    <= use_gpio ? gpio_out_reg[gi] : func_out_i[gi];
                    pad_oe_o[gi] <= use_gpio ? gpio_oe_reg[gi]  : func_oe_i[gi];
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i || pwr_lost) begin
                    pad_pu_o[gi] <= 1'b1;
                    pad_pd_o[gi] <= 1'b0;
                end else if (ce_i) begin
                    pad_pu_o[gi] <= pull_reg[2*gi +: 2] == LPM_PULL_UP;
                    pad_pd_o[gi] <= pull_reg[2*gi +: 2] == LPM_PULL_DOWN;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_o <= (2*NUM_IFACE)'(`LPM_RST_DRIVE);
        end else if (ce_i) begin
            drive_o <= drive_reg;
        end
    end

    // fixed resistors, firmware has no say
    assign jtag_pu_o     = 3'h7;
    assign jtag_tck_pd_o = 1'b1;

    // ----------------------------------------------------------------
    // power outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_o <= '{phy_en: 1'b1, usb_if_hold: 1'b0, clk_en: 1'b1, pll_en: 1'b1, xtal_en: 1'b1,
                       xcvr_en: 1'b1, core_pwr_en: 1'b1, mem_retain: 1'b1, buf_retain: 1'b1,
                       pc_reset: 1'b0};
        end else if (ce_i) begin
            pwr_o.phy_en      <= mode_next == LPM_NORMAL;
            pwr_o.usb_if_hold <= mode_next == LPM_SUSPEND;
            pwr_o.clk_en      <= mode_next == LPM_NORMAL;
            pwr_o.pll_en      <= mode_next == LPM_NORMAL;
            pwr_o.xtal_en     <= mode_next != LPM_STANDBY;
            pwr_o.xcvr_en     <= mode_next != LPM_STANDBY;
            pwr_o.core_pwr_en <= mode_next != LPM_STANDBY;
            pwr_o.mem_retain  <= !pwr_lost;
            pwr_o.buf_retain  <= mode_next != LPM_STANDBY && !pwr_lost;
            pwr_o.pc_reset    <= pc_reset_reg;
        end
    end

    assign mode_o      = mode_reg;
    assign fw_reload_o = reload_reg;

    // ----------------------------------------------------------------
    // wishbone read and acknowledge
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
        end
    end

    // unmapped offsets read zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i && wb_req) begin
            case (wb_adr_i)
                `LPM_OFS_CTRL:     wb_dat_o <= 32'(cts_pol_reg) << `LPM_CTRL_CTSP_BIT;
                `LPM_OFS_STATUS:   wb_dat_o <= {29'h0, reload_reg, mode_reg};
                `LPM_OFS_WAKE:     wb_dat_o <= {25'h0, wake_reg};
                `LPM_OFS_PULL:     wb_dat_o <= 32'(pull_reg);
                `LPM_OFS_DRIVE:    wb_dat_o <= 32'(drive_reg);
                `LPM_OFS_GPIO_SEL: wb_dat_o <= 32'(gpio_sel_reg);
                `LPM_OFS_GPIO_OUT: wb_dat_o <= 32'(gpio_out_reg);
                `LPM_OFS_GPIO_OE:  wb_dat_o <= 32'(gpio_oe_reg);
                `LPM_OFS_GPIO_IN:  wb_dat_o <= 32'(pad_sync);
                default:           wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ===== verification/lpm_ctrl_monitor.sv
// Purpose: mode assertions
// Assumes: one clock, sync reset
// Notes:   bound into the controller
`timescale 1ns/1ps
module lpm_ctrl_monitor
    import lpm_pkg::*;
#(
    parameter int NUM_CTL = 16,
    parameter int NUM_SER = 8
) (
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    input wire logic                       vbus_det_i,
    input wire logic [NUM_CTL+NUM_SER-1:0] pad_o,
    input wire logic [NUM_CTL+NUM_SER-1:0] pad_oe_o,
    input wire logic [2:0]                 jtag_pu_o,
    input wire logic                       jtag_tck_pd_o,
    input wire lpm_pwr_type                pwr_o,
    input wire lpm_mode_type               mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_susp_pwr; mode_o == LPM_SUSPEND |-> !pwr_o.phy_en && pwr_o.usb_if_hold && !pwr_o.clk_en && !pwr_o.pll_en; endproperty
    a_susp_pwr: assert property (p_susp_pwr) else $error("susp pwr");
    property p_susp_keep; mode_o == LPM_SUSPEND |-> pwr_o.mem_retain && pwr_o.buf_retain; endproperty
    a_susp_keep: assert property (p_susp_keep) else $error("suspend retain");
    property p_stby_pwr; mode_o == LPM_STANDBY |-> !(pwr_o.xtal_en || pwr_o.pll_en || pwr_o.xcvr_en || pwr_o.core_pwr_en); endproperty
    a_stby_pwr: assert property (p_stby_pwr) else $error("stby pwr");
    property p_stby_ram; mode_o == LPM_STANDBY |-> pwr_o.mem_retain && !pwr_o.buf_retain; endproperty
    a_stby_ram: assert property (p_stby_ram) else $error("stby retain");
    // entry edge may still load pads
    property p_pad_hold; mode_o != LPM_NORMAL && $past(mode_o) != LPM_NORMAL |-> $stable(pad_o) && $stable(pad_oe_o); endproperty
    a_pad_hold: assert property (p_pad_hold) else $error("pads moved");
    property p_jtag; jtag_pu_o == 3'h7 && jtag_tck_pd_o; endproperty
    a_jtag: assert property (p_jtag) else $error("jtag pulls");
    property p_mode_step; $past(mode_o) != LPM_NORMAL |-> mode_o == $past(mode_o) || mode_o == LPM_NORMAL; endproperty
    a_mode_step: assert property (p_mode_step) else $error("mode jump");
    property p_stby_pc; $past(mode_o) == LPM_STANDBY && mode_o == LPM_NORMAL |=> pwr_o.pc_reset; endproperty
    a_stby_pc: assert property (p_stby_pc) else $error("no restart");
    property p_vbus_wake; mode_o != LPM_NORMAL && vbus_det_i |-> ##[1:4] mode_o == LPM_NORMAL; endproperty
    a_vbus_wake: assert property (p_vbus_wake) else $error("vbus no wake");
endmodule
bind lpm_ctrl lpm_ctrl_monitor #(.NUM_CTL(NUM_CTL), .NUM_SER(NUM_SER)) u_mon (.*);

// ===== verification/lpm_host_model.sv
// Purpose: host and wake-pin model
// Assumes: bench calls the tasks
// Notes:   pin_o order is the wake-cause order
`timescale 1ns/1ps
module lpm_host_model (
    input  wire logic  clk_i,
    output logic       ext_mbox_wr_o = 1'b0,
    output logic [7:0] ext_mbox_dat_o = 8'h00,
    output logic [6:0] pin_o
);
    logic [6:0] lv_reg   = 7'h00;
    logic       cts_idle = 1'b1;
    // reset pin low-active, cts idles off its wake level
    assign pin_o = {lv_reg[6:3], lv_reg[2] ^ cts_idle, lv_reg[1], ~lv_reg[0]};
    task automatic src(input int k, input logic a);
        @(posedge clk_i);
        lv_reg[k] <= a;
    endtask
    // sent only with nothing outstanding
    task automatic mbox(input logic [7:0] c);
        @(posedge clk_i);
        ext_mbox_wr_o  <= 1'b1;
        ext_mbox_dat_o <= c;
        @(posedge clk_i);
        ext_mbox_wr_o  <= 1'b0;
        ext_mbox_dat_o <= ~c;
    endtask
endmodule

// ===== verification/lpm_ctrl_test.sv
// Purpose: directed bench
// Assumes: host model drives wake pins
// Notes:   pads 1 to 23 loop back into pad_i; pad 0 carries CTL0
`timescale 1ns/1ps
module lpm_ctrl_test;
    import lpm_pkg::*;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         cyc = 1'b0, stb = 1'b0, we = 1'b0, pwr_ok = 1'b1, ce = 1'b1;
    logic [7:0]   adr = 8'h00, mdat, drv;
    logic [31:0]  wdat = 32'h0, rdat, dat_o;
    logic         ack, mwr, fw, jpd;
    logic [6:0]   pin;
    logic [23:0]  fout = 24'h0, po, poe, ppu, ppd;
    logic [2:0]   jpu;
    lpm_pwr_type  pwr;
    lpm_mode_type mode;
    int           err_count = 0, n_checks = 0;
    always #12.5 clk_i = ~clk_i;
    lpm_host_model u_host (.clk_i(clk_i), .ext_mbox_wr_o(mwr), .ext_mbox_dat_o(mdat), .pin_o(pin));
    lpm_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .ext_mbox_wr_i(mwr), .ext_mbox_dat_i(mdat), .usb_dp_i(pin[6]), .usb_dm_i(pin[5]),
        .dual_role_id_pin_i(pin[4]), .vbus_det_i(pin[3]), .uart_cts_i(pin[2]), .reset_pin_n_i(pin[0]),
        .core_pwr_good_i(pwr_ok), .func_out_i(fout), .func_oe_i(fout), .pad_i({po[23:1], pin[1]}),
        .pad_o(po), .pad_oe_o(poe), .pad_pu_o(ppu), .pad_pd_o(ppd), .drive_o(drv), .jtag_pu_o(jpu),
        .jtag_tck_pd_o(jpd), .pwr_o(pwr), .mode_o(mode), .fw_reload_o(fw));
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat_o;
        chk(n < 20, 1'b1, "no ack");
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        wb(1'b0, a, 32'h0);
        chk(rdat, e, m);
    endtask
    task automatic wake(input int k, input logic pc);
        logic s = 1'b0;
        u_host.src(k, 1'b1);
        repeat (8) begin
            @(posedge clk_i);
            s = s | pwr.pc_reset;
        end
        chk(mode, LPM_NORMAL, "no wake");
        chk(s, pc, "restart");
        u_host.src(k, 1'b0);
        repeat (4) @(posedge clk_i);
        rd(8'h0C, 32'h1 << k, "wake cause");
        wb(1'b1, 8'h0C, 32'h7F);
    endtask
    task automatic t_reset();
        rd(8'h08, 32'h4, "status reset");
        rd(8'h10, 32'h5555_5555, "pull reset");
        chk(ppu, 24'hFF_FFFF, "pull-up pads");
        rd(8'h30, 32'h0, "unmapped");
        wb(1'b1, 8'h08, 32'h4);
        rd(8'h08, 32'h0, "reload clear");
    endtask
    task automatic t_pads();
        wb(1'b1, 8'h14, 32'hE4);
        wb(1'b1, 8'h10, 32'h6);
        wb(1'b1, 8'h18, 32'hFF_FFFF);
        wb(1'b1, 8'h1C, 32'hA5_A5A5);
        wb(1'b1, 8'h20, 32'hFF_FFFF);
        repeat (2) @(posedge clk_i);
        chk(drv, 8'hE4, "drive");
        chk({ppu[2:0], ppd[2:0]}, 6'h11, "pull kinds");
        chk(po, 24'hA525A5, "gpio out");
        chk(poe, 24'hFF7FFF, "gpio oe");
    endtask
    task automatic t_suspend();
        logic [23:0] held;
        for (int k = 0; k < 7; k++) begin
            if (k % 2 == 1) begin
                u_host.mbox(8'hA5);
            end else begin
                wb(1'b1, 8'h00, 32'h1);
            end
            repeat (2) @(posedge clk_i);
            chk(mode, LPM_SUSPEND, "susp entry");
            held = po;
            fout <= 24'hFF_FFFF;
            u_host.mbox(8'h5A);
            repeat (3) @(posedge clk_i);
            chk(mode, LPM_SUSPEND, "susp req");
            chk(po, held, "pad hold");
            fout <= 24'h0;
            wake(k, k == 0);
        end
        u_host.mbox(8'h33);
        repeat (3) @(posedge clk_i);
        chk(mode, LPM_NORMAL, "bad code");
    endtask
    task automatic t_standby();
        u_host.cts_idle <= 1'b0;
        wb(1'b1, 8'h00, 32'h4);
        for (int k = 0; k < 4; k++) begin
            if (k == 1) begin
                u_host.mbox(8'h5A);
            end else begin
                wb(1'b1, 8'h00, 32'h6);
            end
            repeat (2) @(posedge clk_i);
            chk(mode, LPM_STANDBY, "stby entry");
            for (int j = 4; j < 7; j++) u_host.src(j, 1'b1);
            repeat (6) @(posedge clk_i);
            chk(mode, LPM_STANDBY, "usb woke");
            for (int j = 4; j < 7; j++) u_host.src(j, 1'b0);
            repeat (4) @(posedge clk_i);
            wake(k, 1'b1);
        end
        rd(8'h18, 32'hFF_FFFF, "gpio kept");
    endtask
    task automatic t_power();
        pwr_ok <= 1'b0;
        repeat (4) @(posedge clk_i);
        pwr_ok <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(fw, 1'b1, "fw pin");
        rd(8'h08, 32'h4, "reload lost");
        rd(8'h18, 32'h0, "config lost");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_pads();
        t_suspend();
        t_standby();
        t_power();
        close_out();
    end
    initial begin
        #400000;
        chk(1'b0, 1'b1, "timeout");
        close_out();
    end
endmodule
